// *** src/temp_sensor_pkg.sv ***
package temp_sensor_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int REF_CLK_HZ        = 40_000_000;
   localparam int UPDATE_PERIOD_MS  = 80;
   localparam int UPDATE_PERIOD_CYC = UPDATE_PERIOD_MS * (REF_CLK_HZ / 1000);
   localparam int PERIOD_CNT_W      = 22;

   // ----------------------------------------------------------------
   // Register pointers
   // ----------------------------------------------------------------
   localparam int         PTR_W                         = 3;
   localparam logic [2:0] PTR_TEMPERATURE_VALUE         = 3'h0;
   localparam logic [2:0] PTR_CONFIG                    = 3'h1;
   localparam logic [2:0] PTR_HYSTERESIS_LIMIT          = 3'h2;
   localparam logic [2:0] PTR_OVERTEMP_LIMIT            = 3'h3;
   localparam logic [2:0] PTR_SINGLE_CONVERSION_TRIGGER = 3'h4;
   localparam logic [2:0] PTR_RESET                     = 3'h0;

   // ----------------------------------------------------------------
   // Reset values and field layout
   // ----------------------------------------------------------------
   localparam logic [15:0] TEMPERATURE_VALUE_RESET = 16'h0000;
   localparam logic [15:0] HYSTERESIS_LIMIT_RESET  = 16'h4b00;
   localparam logic [15:0] OVERTEMP_LIMIT_RESET    = 16'h5000;
   localparam logic [15:0] LIMIT_WRITE_MASK        = 16'hfff0;
   localparam logic [7:0]  CONFIG_RESET            = 8'h00;
   localparam logic [7:0]  CONFIG_WRITE_MASK       = 8'hbf;
   localparam int          CFG_SHUTDOWN_BIT        = 0;
   localparam int          CFG_INTERRUPT_BIT       = 1;
   localparam int          CFG_POLARITY_BIT        = 2;
   localparam int          CFG_ONESHOT_MODE_BIT    = 5;
   localparam int          PTR_FIELD_LSB           = 8;
   localparam int          RESULT_LSB              = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {REQ_PTR_WR, REQ_REG_WR, REQ_REG_RD} link_req_kind_t;

   typedef struct packed {
      link_req_kind_t kind;
      logic           two_byte;
      logic [15:0]    data;
   } link_req_t;

   typedef enum {CONV_IDLE, CONV_BUSY} conv_state_t;

endpackage : temp_sensor_pkg

// *** src/level_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   // First stage feeds only the second stage.
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : level_sync
`default_nettype wire

// *** src/link_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module link_port (
   input  wire logic                      link_clk,
   input  wire logic                      reset_n,
   input  wire logic                      req_valid,
   input  wire temp_sensor_pkg::link_req_t req,
   input  wire logic                      ack_toggle_in,
   input  wire logic [15:0]               resp_data_in,
   output logic                           busy,
   output logic                           ack,
   output logic [15:0]                    rd_data,
   output temp_sensor_pkg::link_req_t     hold,
   output logic                           req_toggle
);
   // ----------------------------------------------------------------
   // Link-side half of the request handshake
   // ----------------------------------------------------------------
   // The held request stays put until the core answers, so the core may
   // read it as a stable word once the toggle has crossed.
   logic                       ack_tog_s;
   logic                       ack_seen_r, ack_seen_nxt;
   logic                       busy_nxt, ack_nxt, req_tog_nxt;
   logic [15:0]                rd_data_nxt;
   temp_sensor_pkg::link_req_t hold_nxt;

   level_sync #(.WIDTH(1)) u_ack_sync (
      .clk      (link_clk),
      .reset_n  (reset_n),
      .async_in (ack_toggle_in),
      .sync_out (ack_tog_s)
   );

   always_comb begin
      busy_nxt     = busy;
      ack_nxt      = 1'b0;
      rd_data_nxt  = rd_data;
      hold_nxt     = hold;
      req_tog_nxt  = req_toggle;
      ack_seen_nxt = ack_seen_r;
      if (req_valid && !busy) begin
         hold_nxt    = req;
         req_tog_nxt = ~req_toggle;
         busy_nxt    = 1'b1;
      end
      if (busy && (ack_tog_s != ack_seen_r)) begin
         ack_seen_nxt = ack_tog_s;
         busy_nxt     = 1'b0;
         ack_nxt      = 1'b1;
         rd_data_nxt  = resp_data_in;
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy       <= 1'b0;
         ack        <= 1'b0;
         rd_data    <= 16'h0000;
         hold       <= '0;
         req_toggle <= 1'b0;
         ack_seen_r <= 1'b0;
      end else begin
         busy       <= busy_nxt;
         ack        <= ack_nxt;
         rd_data    <= rd_data_nxt;
         hold       <= hold_nxt;
         req_toggle <= req_tog_nxt;
         ack_seen_r <= ack_seen_nxt;
      end
   end
endmodule : link_port
`default_nettype wire

// *** src/temp_sensor_conversion_alert.sv ***
// Operation
// R1: Normal mode starts a conversion every 80 ms.
// R2: Store result; compare with overtemp limit (80 C).
// R3: Reads during conversion return last result.
// R4: Bus traffic never disturbs conversion sequencing.
// R5: Shutdown stops conversions, freezes temperature value.
// R6: Register access keeps working in shutdown.
// R7: Configuration bit 0 selects shutdown.
// R8: Shutdown write to pointer 4 triggers conversion.
// R9: One-shot powers up, converts, compares, returns.
// R10: Comparator alert clears below hysteresis limit.
// R11: Interrupt alert clears after read and hysteresis.
// R12: Alert active level selectable high or low.
// R13: Two bytes full value; one byte upper eight.
// R14: Encoding spans -128 C to 127 C.
// R15: Twelve-bit left-justified, low four bits zero.
// R16: Configuration bit 1 selects interrupt style.
// R17: Configuration bit 2 selects active high.
// R18: Pointer low three bits select register, reset zero.
// R19: One-shot updates like a periodic conversion.
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_conversion_alert #(
   parameter int CONV_PERIOD_CYCLES = temp_sensor_pkg::UPDATE_PERIOD_CYC
) (
   input  wire logic                      REF_CLK,
   input  wire logic                      RESET_N,
   input  wire logic                      LINK_CLK,
   input  wire logic                      LINK_REQ_VALID,
   input  wire temp_sensor_pkg::link_req_t LINK_REQ,
   output logic                           LINK_BUSY,
   output logic                           LINK_ACK,
   output logic [15:0]                    LINK_RD_DATA,
   output logic                           ADC_CONV_START,
   output logic                           ADC_MEAS_POWER,
   input  wire logic                      ADC_RESULT_VALID,
   input  wire logic [11:0]               ADC_RESULT_CODE,
   output logic                           OVERTEMP_ALERT_PIN_OUT,
   output logic                           OVERTEMP_ALERT_PIN_OE
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [temp_sensor_pkg::PERIOD_CNT_W-1:0] PERIOD_LAST =
      temp_sensor_pkg::PERIOD_CNT_W'(CONV_PERIOD_CYCLES - 1);

   temp_sensor_pkg::link_req_t  hold;
   logic                        req_tog_link, req_tog_s;
   logic                        req_seen_r, req_seen_nxt;
   logic                        ack_tog_r, ack_tog_nxt;
   logic [15:0]                 resp_r, resp_nxt;
   logic [2:0]                  ptr_r, ptr_nxt;
   logic [15:0]                 temp_r, temp_nxt;
   logic [7:0]                  config_r, config_nxt;
   logic [15:0]                 hyst_r, hyst_nxt;
   logic [15:0]                 tos_r, tos_nxt;
   logic [temp_sensor_pkg::PERIOD_CNT_W-1:0] period_cnt_r, period_cnt_nxt;
   temp_sensor_pkg::conv_state_t conv_state_r, conv_state_nxt;
   logic                        start_nxt, power_nxt;
   logic                        oneshot_pend_r, oneshot_pend_nxt;
   logic                        oneshot_conv_r, oneshot_conv_nxt;
   logic                        comp_alert_r, comp_alert_nxt;
   logic                        int_alert_r, int_alert_nxt;
   logic                        int_read_r, int_read_nxt;
   logic                        below_r, below_nxt;
   logic                        pin_out_nxt, pin_oe_nxt;
   logic                        new_req, read_event, write_event, stopped, tick, done;
   logic                        over_now, below_now, alert_active;
   logic [15:0]                 new_temp, sel_word;

   // ----------------------------------------------------------------
   // Link crossing
   // ----------------------------------------------------------------
   link_port u_link_port (
      .link_clk      (LINK_CLK),
      .reset_n       (RESET_N),
      .req_valid     (LINK_REQ_VALID),
      .req           (LINK_REQ),
      .ack_toggle_in (ack_tog_r),
      .resp_data_in  (resp_r),
      .busy          (LINK_BUSY),
      .ack           (LINK_ACK),
      .rd_data       (LINK_RD_DATA),
      .hold          (hold),
      .req_toggle    (req_tog_link)
   );

   level_sync #(.WIDTH(1)) u_req_sync (
      .clk      (REF_CLK),
      .reset_n  (RESET_N),
      .async_in (req_tog_link),
      .sync_out (req_tog_s)
   );

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   assign new_req     = req_tog_s != req_seen_r;
   assign read_event  = new_req && (hold.kind == temp_sensor_pkg::REQ_REG_RD);
   assign write_event = new_req && (hold.kind == temp_sensor_pkg::REQ_REG_WR);

   always_comb begin
      unique case (ptr_r)
         temp_sensor_pkg::PTR_TEMPERATURE_VALUE: sel_word = temp_r;
         temp_sensor_pkg::PTR_CONFIG:            sel_word = {config_r, 8'h00};
         temp_sensor_pkg::PTR_HYSTERESIS_LIMIT:  sel_word = hyst_r;
         temp_sensor_pkg::PTR_OVERTEMP_LIMIT:    sel_word = tos_r;
         default:                                sel_word = 16'h0000;
      endcase
   end

   // Access is never gated by the conversion state or by shutdown.
   always_comb begin // R6
      req_seen_nxt = req_seen_r;
      ack_tog_nxt  = ack_tog_r;
      resp_nxt     = resp_r;
      ptr_nxt      = ptr_r;
      config_nxt   = config_r;
      hyst_nxt     = hyst_r;
      tos_nxt      = tos_r;
      if (new_req) begin
         req_seen_nxt = req_tog_s;
         ack_tog_nxt  = ~ack_tog_r;
         resp_nxt     = 16'h0000;
         if (hold.kind == temp_sensor_pkg::REQ_PTR_WR) begin
            ptr_nxt = hold.data[temp_sensor_pkg::PTR_FIELD_LSB +: temp_sensor_pkg::PTR_W]; // R18
         end
         if (read_event) begin
            resp_nxt = hold.two_byte ? sel_word : {sel_word[15:8], 8'h00}; // R13
         end
      end
      if (write_event) begin
         unique case (ptr_r)
            temp_sensor_pkg::PTR_CONFIG: begin
               config_nxt = hold.data[15:8] & temp_sensor_pkg::CONFIG_WRITE_MASK;
            end
            temp_sensor_pkg::PTR_HYSTERESIS_LIMIT: begin
               hyst_nxt = (hold.two_byte ? hold.data : {hold.data[15:8], hyst_r[7:0]})
                          & temp_sensor_pkg::LIMIT_WRITE_MASK;
            end
            temp_sensor_pkg::PTR_OVERTEMP_LIMIT: begin
               tos_nxt = (hold.two_byte ? hold.data : {hold.data[15:8], tos_r[7:0]})
                         & temp_sensor_pkg::LIMIT_WRITE_MASK;
            end
            default: begin
               config_nxt = config_r;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencing
   // ----------------------------------------------------------------
   // One-shot mode also parks the converter; only the trigger wakes it.
   assign stopped  = config_r[temp_sensor_pkg::CFG_SHUTDOWN_BIT]
                   | config_r[temp_sensor_pkg::CFG_ONESHOT_MODE_BIT]; // R7
   assign tick     = !stopped && (period_cnt_r == '0); // R1
   assign done     = (conv_state_r == temp_sensor_pkg::CONV_BUSY) && ADC_RESULT_VALID;
   assign new_temp = {ADC_RESULT_CODE, 4'h0}; // R15
   // Signed compare over the full two's complement span.
   assign over_now  = $signed(new_temp) > $signed(tos_r); // R14
   assign below_now = $signed(new_temp) < $signed(hyst_r);

   // Sequencing reads no bus signal except the one-shot trigger.
   always_comb begin // R4
      period_cnt_nxt   = period_cnt_r;
      conv_state_nxt   = conv_state_r;
      start_nxt        = 1'b0;
      power_nxt        = ADC_MEAS_POWER;
      oneshot_pend_nxt = oneshot_pend_r;
      oneshot_conv_nxt = oneshot_conv_r;
      temp_nxt         = temp_r;
      if (stopped) begin
         period_cnt_nxt = '0; // R5
      end else if (period_cnt_r == PERIOD_LAST) begin
         period_cnt_nxt = '0;
      end else begin
         period_cnt_nxt = period_cnt_r + 1'b1;
      end
      unique case (conv_state_r)
         temp_sensor_pkg::CONV_IDLE: begin
            if (tick || oneshot_pend_r) begin
               conv_state_nxt   = temp_sensor_pkg::CONV_BUSY; // R9
               start_nxt        = 1'b1;
               power_nxt        = 1'b1;
               oneshot_conv_nxt = !tick;
               oneshot_pend_nxt = 1'b0;
            end
         end
         temp_sensor_pkg::CONV_BUSY: begin
            if (ADC_RESULT_VALID) begin
               // The one-shot result takes the same path as a periodic one.
               temp_nxt       = new_temp; // R2 R3 R19
               conv_state_nxt = temp_sensor_pkg::CONV_IDLE;
               power_nxt      = 1'b0; // R9
            end else if (stopped && !oneshot_conv_r) begin
               // Abandon a periodic conversion so the stored value stays frozen.
               conv_state_nxt = temp_sensor_pkg::CONV_IDLE; // R5
               power_nxt      = 1'b0;
            end
         end
      endcase
      if (write_event && stopped && (ptr_r == temp_sensor_pkg::PTR_SINGLE_CONVERSION_TRIGGER)) begin
         oneshot_pend_nxt = 1'b1; // R8
      end
   end

   // ----------------------------------------------------------------
   // Alert output
   // ----------------------------------------------------------------
   always_comb begin
      comp_alert_nxt = comp_alert_r;
      int_alert_nxt  = int_alert_r;
      int_read_nxt   = int_read_r;
      below_nxt      = below_r;
      if (done) begin
         below_nxt = below_now;
         if (over_now) begin
            comp_alert_nxt = 1'b1; // R2
         end else if (below_now) begin
            comp_alert_nxt = 1'b0; // R10
         end
      end
      if (int_alert_r && read_event) begin
         int_read_nxt = 1'b1;
      end
      // A fresh over-limit result wins over a pending clear.
      if (done && over_now) begin
         int_alert_nxt = 1'b1;
      end else if (int_alert_r && (int_read_r || read_event) && (done ? below_now : below_r)) begin
         int_alert_nxt = 1'b0; // R11
         int_read_nxt  = 1'b0;
      end
   end

   assign alert_active = config_r[temp_sensor_pkg::CFG_INTERRUPT_BIT] ? int_alert_r : comp_alert_r; // R16
   // Open drain: the pin is pulled low only; a high level comes from the pull-up.
   assign pin_out_nxt  = alert_active ? config_r[temp_sensor_pkg::CFG_POLARITY_BIT]
                                      : ~config_r[temp_sensor_pkg::CFG_POLARITY_BIT]; // R12 R17
   assign pin_oe_nxt   = ~pin_out_nxt;

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         req_seen_r             <= 1'b0;
         ack_tog_r              <= 1'b0;
         resp_r                 <= 16'h0000;
         ptr_r                  <= temp_sensor_pkg::PTR_RESET;
         temp_r                 <= temp_sensor_pkg::TEMPERATURE_VALUE_RESET;
         config_r               <= temp_sensor_pkg::CONFIG_RESET;
         hyst_r                 <= temp_sensor_pkg::HYSTERESIS_LIMIT_RESET;
         tos_r                  <= temp_sensor_pkg::OVERTEMP_LIMIT_RESET;
         period_cnt_r           <= '0;
         conv_state_r           <= temp_sensor_pkg::CONV_IDLE;
         ADC_CONV_START         <= 1'b0;
         ADC_MEAS_POWER         <= 1'b0;
         oneshot_pend_r         <= 1'b0;
         oneshot_conv_r         <= 1'b0;
         comp_alert_r           <= 1'b0;
         int_alert_r            <= 1'b0;
         int_read_r             <= 1'b0;
         below_r                <= 1'b0;
         OVERTEMP_ALERT_PIN_OUT <= 1'b1;
         OVERTEMP_ALERT_PIN_OE  <= 1'b0;
      end else begin
         req_seen_r             <= req_seen_nxt;
         ack_tog_r              <= ack_tog_nxt;
         resp_r                 <= resp_nxt;
         ptr_r                  <= ptr_nxt;
         temp_r                 <= temp_nxt;
         config_r               <= config_nxt;
         hyst_r                 <= hyst_nxt;
         tos_r                  <= tos_nxt;
         period_cnt_r           <= period_cnt_nxt;
         conv_state_r           <= conv_state_nxt;
         ADC_CONV_START         <= start_nxt;
         ADC_MEAS_POWER         <= power_nxt;
         oneshot_pend_r         <= oneshot_pend_nxt;
         oneshot_conv_r         <= oneshot_conv_nxt;
         comp_alert_r           <= comp_alert_nxt;
         int_alert_r            <= int_alert_nxt;
         int_read_r             <= int_read_nxt;
         below_r                <= below_nxt;
         OVERTEMP_ALERT_PIN_OUT <= pin_out_nxt;
         OVERTEMP_ALERT_PIN_OE  <= pin_oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   chk_period_start: assert property ( // R1
      (tick && conv_state_r == temp_sensor_pkg::CONV_IDLE) |=> ADC_CONV_START && ADC_MEAS_POWER)
      else $error("periodic conversion did not start");
   chk_period_wrap: assert property ( // R1
      (!stopped && period_cnt_r == PERIOD_LAST) ##1 !stopped |-> period_cnt_r == '0)
      else $error("period counter did not wrap");
   chk_temp_update: assert property ( // R2
      done |=> temp_r == {$past(ADC_RESULT_CODE), 4'h0} && conv_state_r == temp_sensor_pkg::CONV_IDLE)
      else $error("temperature value not stored");
   chk_temp_hold: assert property ( // R3
      !done |=> $stable(temp_r))
      else $error("temperature value changed without a result");
   chk_no_start_stopped: assert property ( // R5
      (stopped && !oneshot_pend_r) |=> !ADC_CONV_START)
      else $error("conversion started in shutdown");
   chk_oneshot_start: assert property ( // R8
      (write_event && stopped && ptr_r == temp_sensor_pkg::PTR_SINGLE_CONVERSION_TRIGGER
       && conv_state_r == temp_sensor_pkg::CONV_IDLE) |-> ##2 ADC_CONV_START)
      else $error("one-shot trigger did not start a conversion");
   chk_oneshot_power: assert property ( // R9
      done |=> !ADC_MEAS_POWER)
      else $error("measurement path stayed powered");
   chk_comp_clear: assert property ( // R10
      (done && !over_now && below_now) |=> !comp_alert_r)
      else $error("comparator alert did not clear");
   chk_int_hold: assert property ( // R11
      (int_alert_r && !int_read_r && !read_event) |=> int_alert_r)
      else $error("interrupt alert cleared without a read");
   chk_pin_drive: assert property ( // R12
      OVERTEMP_ALERT_PIN_OE == !OVERTEMP_ALERT_PIN_OUT)
      else $error("alert pin enable does not match its level");
   chk_low_zero: assert property ( // R15
      temp_r[3:0] == 4'h0 && hyst_r[3:0] == 4'h0 && tos_r[3:0] == 4'h0)
      else $error("low four bits not zero");
   chk_ptr_write: assert property ( // R18
      (new_req && hold.kind == temp_sensor_pkg::REQ_PTR_WR) |=> ptr_r == $past(hold.data[10:8]))
      else $error("pointer not loaded");

   cov_periodic: cover property (tick ##1 ADC_CONV_START ##[1:300] done);
   cov_oneshot: cover property (oneshot_pend_r ##1 ADC_CONV_START);
   cov_int_clear: cover property (int_alert_r ##1 !int_alert_r);
   cov_comp_alert: cover property (!comp_alert_r ##1 comp_alert_r);

endmodule : temp_sensor_conversion_alert
`default_nettype wire

// *** verification/link_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
   output logic                       lclk,
   output logic                       valid,
   output temp_sensor_pkg::link_req_t req,
   input  wire logic                  busy,
   input  wire logic                  ack,
   input  wire logic [15:0]           rd_data
);
   logic run = 1'b0;
   initial begin
      valid = 1'b0;
      req = '0;
   end
   // The engine clocks the link only while a transfer is open, so the core never sees a free link clock.
   always #7.5 lclk = run ? ~lclk : 1'b0;
   task automatic xfer(input logic [1:0] k, input logic two, input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      run = 1'b1;
      @(negedge lclk);
      req = {k, two, d};
      valid = 1'b1;
      @(posedge lclk);
      while (busy !== 1'b0 && n < 60) begin
         @(posedge lclk);
         n++;
      end
      @(negedge lclk);
      valid = 1'b0;
      req.data = ~d;
      while (ack !== 1'b1 && n < 60) begin
         @(negedge lclk);
         n++;
      end
      if (n >= 60) begin
         temp_sensor_conversion_alert_bench.fails++;
         $display("unexpected at %0t: link transfer not answered", $time);
      end
      q = rd_data;
      run = 1'b0;
   endtask : xfer
endmodule : link_host_model
`default_nettype wire

// *** verification/temp_sensor_conversion_alert_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_conversion_alert_bench;
   localparam int PER = 200;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic rvalid = 1'b0;
   logic [11:0] rcode = 12'h000;
   logic lclk, lvalid, lbusy, lack, start, power, pin_out, pin_oe;
   logic [15:0] rdata, q;
   temp_sensor_pkg::link_req_t lreq;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int last_start = 0;
   int gap = 0;
   int n;
   always #12.5 ref_clk = ~ref_clk;
   link_host_model host (.lclk(lclk), .valid(lvalid), .req(lreq), .busy(lbusy), .ack(lack), .rd_data(rdata));
   temp_sensor_conversion_alert #(.CONV_PERIOD_CYCLES(PER)) dut (.REF_CLK(ref_clk), .RESET_N(reset_n),
      .LINK_CLK(lclk), .LINK_REQ_VALID(lvalid), .LINK_REQ(lreq), .LINK_BUSY(lbusy), .LINK_ACK(lack),
      .LINK_RD_DATA(rdata), .ADC_CONV_START(start), .ADC_MEAS_POWER(power), .ADC_RESULT_VALID(rvalid),
      .ADC_RESULT_CODE(rcode), .OVERTEMP_ALERT_PIN_OUT(pin_out), .OVERTEMP_ALERT_PIN_OE(pin_oe));
   always @(negedge ref_clk) begin
      cyc++;
      if (start === 1'b1) begin
         gap = cyc - last_start;
         last_start = cyc;
      end
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [2:0] p, input logic two, output logic [15:0] v);
      host.xfer(2'd0, 1'b0, {5'h00, p, 8'h00}, v);
      host.xfer(2'd2, two, 16'h0000, v);
   endtask : rd
   task automatic wr(input logic [2:0] p, input logic [15:0] d);
      logic [15:0] v;
      host.xfer(2'd0, 1'b0, {5'h00, p, 8'h00}, v);
      host.xfer(2'd1, 1'b0, d, v);
   endtask : wr
   task automatic pin(input logic act, input logic pol);
      chk({14'h0000, pin_out, pin_oe}, {14'h0000, act ~^ pol, act ^ pol});
   endtask : pin
   // Answers one conversion; with reads on, the old value must show while the sample is in flight.
   // Waits on the power level, not the start pulse: the pulse may pass while a link transfer is still open.
   task automatic conv(input logic [11:0] c, input logic [15:0] prev, input logic reads);
      int k;
      logic [15:0] v;
      k = 0;
      while (power !== 1'b1 && k < 400) begin
         @(negedge ref_clk);
         k++;
      end
      chk({15'h0000, power}, 16'h0001);
      if (reads) rd(3'h0, 1'b1, v);
      if (reads) chk(v, prev);
      @(negedge ref_clk);
      rvalid = 1'b1;
      rcode = c;
      @(negedge ref_clk);
      rvalid = 1'b0;
      rcode = ~c;
      repeat (3) @(negedge ref_clk);
      rd(3'h0, 1'b1, v);
      chk(v, {c, 4'h0});
   endtask : conv
   task automatic t_reset;
      rd(3'h3, 1'b1, q);
      chk(q, 16'h5000);
      rd(3'h2, 1'b1, q);
      chk(q, 16'h4b00);
      rd(3'h1, 1'b1, q);
      chk(q, 16'h0000);
      pin(1'b0, 1'b0);
   endtask : t_reset
   task automatic t_compare;
      conv(12'h190, 16'h0000, 1'b1);
      conv(12'h7f5, 16'h1900, 1'b1);
      chk(gap[15:0], PER[15:0]);
      rd(3'h0, 1'b0, q);
      chk(q, 16'h7f00);
      pin(1'b1, 1'b0);
      conv(12'h4a0, 16'h7f50, 1'b0);
      pin(1'b0, 1'b0);
      conv(12'h800, 16'h4a00, 1'b1);
   endtask : t_compare
   task automatic t_interrupt;
      wr(3'h1, 16'h0200);
      conv(12'h7f5, 16'h0000, 1'b0);
      pin(1'b1, 1'b0);
      conv(12'h4a0, 16'h0000, 1'b0);
      // The read closing the previous conversion came while the alert stood, so falling below clears it.
      pin(1'b0, 1'b0);
      host.xfer(2'd2, 1'b1, 16'h0000, q);
      repeat (4) @(negedge ref_clk);
      pin(1'b0, 1'b0);
   endtask : t_interrupt
   task automatic t_shutdown;
      wr(3'h1, 16'h0500);
      pin(1'b0, 1'b1);
      n = cyc;
      repeat (2 * PER) @(negedge ref_clk);
      chk({15'h0000, last_start < n}, 16'h0001);
      rd(3'h0, 1'b1, q);
      chk(q, 16'h4a00);
      wr(3'h4, 16'h5a00);
      conv(12'h7f5, 16'h4a00, 1'b1);
      pin(1'b1, 1'b1);
   endtask : t_shutdown
   task automatic results;
      $display("compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      repeat (4) @(negedge ref_clk);
      reset_n = 1'b1;
      t_reset();
      t_compare();
      t_interrupt();
      t_shutdown();
      results();
   end
endmodule : temp_sensor_conversion_alert_bench
`default_nettype wire
